/* logic/mrsf_framer.sv */
// Station frame engine: takes received bytes, checks and executes word
// read/write requests against a parameter store, and builds replies.
// Assumes a byte UART on the same clock and a handshaked parameter store.
`default_nettype none

module mrsf_framer #(
	parameter int GAP_CYCLES = mrsf_pkg::GAP_CYCLES
) (
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic [7:0] STATION_ADDR,
	input wire logic RX_VALID,
	input wire logic [7:0] RX_DATA,
	output logic TX_VALID,
	output logic [7:0] TX_DATA,
	input wire logic TX_READY,
	input wire logic TX_BUSY,
	output logic TX_EN,
	output logic PAR_REQ,
	output mrsf_pkg::mrsf_par_t PAR,
	input wire logic PAR_ACK,
	input wire logic [7:0] PAR_EXC,
	input wire logic [15:0] PAR_RDATA
);
	localparam int GW = $clog2(GAP_CYCLES + 1);
	localparam logic [GW-1:0] GAP_END = GW'(GAP_CYCLES);

	typedef enum {S_IDLE, S_EXEC, S_SEND, S_DRAIN, S_HOLD} mrsf_state_t;

	// ----------------------------------------------------------------
	// Check value step
	// ----------------------------------------------------------------
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			if (r[0]) begin
				r = (r >> 1) ^ mrsf_pkg::CRC_POLY;
			end else begin
				r = r >> 1;
			end
		end
		return r;
	endfunction : crc_step

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	mrsf_state_t state, next_state;
	logic [7:0] rx_buf [8];
	logic [7:0] next_rx_buf [8];
	logic [3:0] rx_cnt, next_rx_cnt;
	logic [15:0] crc, next_crc;
	logic [15:0] crc_snap, next_crc_snap;
	logic [GW-1:0] gap_cnt, next_gap_cnt;
	logic [15:0] words [12];
	logic [15:0] next_words [12];
	logic [3:0] word_idx, next_word_idx;
	logic [7:0] exc, next_exc;
	logic [4:0] tx_idx, next_tx_idx;
	logic next_tx_valid, next_tx_en, next_par_req;
	logic [7:0] next_tx_data;
	mrsf_pkg::mrsf_par_t next_par;

	// Decoded request fields, valid while not collecting
	logic bcast, own, is_read, is_write, cmd_ok, crc_ok, cnt_ok, tx_fire;
	logic [15:0] req_cnt;
	logic [4:0] body_len;
	logic [7:0] body_byte;

	always_comb begin
		bcast = rx_buf[0] == mrsf_pkg::ADDR_BCAST;
		own = rx_buf[0] == STATION_ADDR && STATION_ADDR != mrsf_pkg::ADDR_BCAST
			&& STATION_ADDR <= mrsf_pkg::ADDR_MAX;
		is_read = rx_buf[1] == mrsf_pkg::CMD_READ;
		is_write = rx_buf[1] == mrsf_pkg::CMD_WRITE;
		cmd_ok = is_read || is_write;
		req_cnt = {rx_buf[4], rx_buf[5]};
		cnt_ok = req_cnt != 16'h0000 && req_cnt <= mrsf_pkg::MAX_WORDS;
		crc_ok = {rx_buf[7], rx_buf[6]} == crc_snap;
		tx_fire = !TX_VALID || TX_READY;
		if (exc != mrsf_pkg::EXC_NONE) begin
			body_len = 5'd3;
		end else if (is_read) begin
			body_len = 5'd3 + {req_cnt[3:0], 1'b0};
		end else begin
			body_len = 5'd6;
		end
	end

	// Reply byte at position tx_idx, check bytes excluded
	always_comb begin
		logic [3:0] k;
		k = 4'((tx_idx - 5'd3) >> 1);
		body_byte = rx_buf[0];
		if (tx_idx == 5'd0) begin
			body_byte = rx_buf[0];
		end else if (exc != mrsf_pkg::EXC_NONE) begin
			if (tx_idx == 5'd1) begin
				body_byte = rx_buf[1] | mrsf_pkg::CMD_EXC_BIT;
			end else begin
				body_byte = exc;
			end
		end else if (is_read) begin
			if (tx_idx == 5'd1) begin
				body_byte = rx_buf[1];
			end else if (tx_idx == 5'd2) begin
				body_byte = {req_cnt[6:0], 1'b0};
			end else if (tx_idx[0]) begin
				body_byte = words[k][15:8];
			end else begin
				body_byte = words[k][7:0];
			end
		end else begin
			body_byte = rx_buf[tx_idx[2:0]]; // write echo
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_rx_buf = rx_buf;
		next_rx_cnt = rx_cnt;
		next_crc = crc;
		next_crc_snap = crc_snap;
		next_gap_cnt = gap_cnt;
		next_words = words;
		next_word_idx = word_idx;
		next_exc = exc;
		next_tx_idx = tx_idx;
		next_tx_valid = TX_VALID;
		next_tx_data = TX_DATA;
		next_tx_en = TX_EN;
		next_par_req = PAR_REQ;
		next_par = PAR;
		case (state)
			S_IDLE: begin
				if (gap_cnt != GAP_END) begin
					next_gap_cnt = gap_cnt + GW'(1);
				end
				if (RX_VALID) begin
					next_gap_cnt = '0;
					if (rx_cnt < mrsf_pkg::REQ_LEN) begin
						next_rx_buf[rx_cnt[2:0]] = RX_DATA;
					end
					if (rx_cnt < mrsf_pkg::CRC_POS) begin
						next_crc = crc_step(crc, RX_DATA);
					end
					if (rx_cnt == mrsf_pkg::CRC_POS) begin
						next_crc_snap = crc;
					end
					if (rx_cnt <= mrsf_pkg::REQ_LEN) begin
						next_rx_cnt = rx_cnt + 4'd1;
					end
				end else if (gap_cnt == GAP_END && rx_cnt != 4'd0) begin
					// Frame closed by the gap; the next byte starts afresh
					next_rx_cnt = 4'd0;
					next_crc = mrsf_pkg::CRC_INIT;
					next_exc = mrsf_pkg::EXC_NONE;
					next_word_idx = 4'd0;
					next_par.addr = {rx_buf[2], rx_buf[3]};
					next_par.wdata = {rx_buf[4], rx_buf[5]};
					next_par.we = is_write;
					if (rx_cnt != mrsf_pkg::REQ_LEN || !crc_ok || !(own || bcast)) begin
						next_state = S_IDLE;
					end else if (!cmd_ok) begin
						next_exc = mrsf_pkg::EXC_CMD;
						next_state = bcast ? S_IDLE : S_SEND;
					end else if (is_read && bcast) begin
						next_state = S_IDLE;
					end else if (is_read && !cnt_ok) begin
						next_exc = mrsf_pkg::EXC_DATA;
						next_state = S_SEND;
					end else begin
						next_state = S_EXEC;
						next_par_req = 1'b1;
					end
					if (next_state == S_SEND) begin
						next_tx_idx = 5'd0;
						next_tx_en = 1'b1;
					end
				end
			end
			S_EXEC: begin
				if (PAR_REQ && PAR_ACK) begin
					next_par_req = 1'b0;
					if (PAR_EXC != mrsf_pkg::EXC_NONE) begin
						next_exc = PAR_EXC;
						next_state = S_SEND;
					end else if (is_read) begin
						next_words[word_idx] = PAR_RDATA;
						next_word_idx = word_idx + 4'd1;
						next_par.addr = PAR.addr + 16'h0001;
						if (word_idx + 4'd1 == req_cnt[3:0]) begin
							next_state = S_SEND;
						end
					end else begin
						next_state = S_SEND;
					end
					if (bcast && next_state == S_SEND) begin
						next_state = S_HOLD;
						next_gap_cnt = '0;
					end else if (next_state == S_SEND) begin
						next_tx_idx = 5'd0;
						next_tx_en = 1'b1;
					end
				end else if (!PAR_REQ) begin
					next_par_req = 1'b1;
				end
			end
			S_SEND: begin
				if (tx_fire) begin
					if (tx_idx < body_len) begin
						next_tx_valid = 1'b1;
						next_tx_data = body_byte;
						next_crc = crc_step(crc, body_byte);
						next_tx_idx = tx_idx + 5'd1;
					end else if (tx_idx == body_len) begin
						next_tx_valid = 1'b1;
						next_tx_data = crc[7:0];
						next_tx_idx = tx_idx + 5'd1;
					end else if (tx_idx == body_len + 5'd1) begin
						next_tx_valid = 1'b1;
						next_tx_data = crc[15:8];
						next_tx_idx = tx_idx + 5'd1;
					end else begin
						next_tx_valid = 1'b0;
						next_state = S_DRAIN;
					end
				end
			end
			S_DRAIN: begin
				if (!TX_BUSY) begin
					next_tx_en = 1'b0;
					next_state = S_HOLD;
					next_gap_cnt = '0;
				end
			end
			S_HOLD: begin
				// Quiet line after our own frame or an executed broadcast before listening again
				next_crc = mrsf_pkg::CRC_INIT;
				if (gap_cnt == GAP_END) begin
					next_state = S_IDLE;
					next_gap_cnt = '0;
				end else begin
					next_gap_cnt = gap_cnt + GW'(1);
				end
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			state <= S_IDLE;
			rx_cnt <= 4'd0;
			crc <= mrsf_pkg::CRC_INIT;
			crc_snap <= 16'h0000;
			gap_cnt <= '0;
			word_idx <= 4'd0;
			exc <= 8'h00;
			tx_idx <= 5'd0;
			TX_VALID <= 1'b0;
			TX_DATA <= 8'h00;
			TX_EN <= 1'b0;
			PAR_REQ <= 1'b0;
			PAR <= '0;
			for (int i = 0; i < 8; i++) begin
				rx_buf[i] <= 8'h00;
			end
			for (int i = 0; i < 12; i++) begin
				words[i] <= 16'h0000;
			end
		end else begin
			state <= next_state;
			rx_cnt <= next_rx_cnt;
			crc <= next_crc;
			crc_snap <= next_crc_snap;
			gap_cnt <= next_gap_cnt;
			word_idx <= next_word_idx;
			exc <= next_exc;
			tx_idx <= next_tx_idx;
			TX_VALID <= next_tx_valid;
			TX_DATA <= next_tx_data;
			TX_EN <= next_tx_en;
			PAR_REQ <= next_par_req;
			PAR <= next_par;
			rx_buf <= next_rx_buf;
			words <= next_words;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_accept;
		TX_VALID && TX_READY;
	endsequence

	sequence s_stall;
		TX_VALID && !TX_READY;
	endsequence

	property p_no_bcast_reply;
		@(posedge CLOCK) disable iff (RESET) state == S_SEND |-> !bcast;
	endproperty
	a_no_bcast_reply: assert property (p_no_bcast_reply) else $error("reply to broadcast");

	property p_drive_only_replying;
		@(posedge CLOCK) disable iff (RESET) TX_EN |-> (state == S_SEND || state == S_DRAIN);
	endproperty
	a_drive_only_replying: assert property (p_drive_only_replying) else $error("bus driven idle");

	property p_tx_hold;
		@(posedge CLOCK) disable iff (RESET) s_stall |=> TX_VALID && $stable(TX_DATA);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("byte dropped while stalled");

	property p_hold_gap;
		@(posedge CLOCK) disable iff (RESET)
			state == S_HOLD && gap_cnt != GAP_END |=> state == S_HOLD;
	endproperty
	a_hold_gap: assert property (p_hold_gap) else $error("gap after frame too short");

	property p_crc_preset;
		@(posedge CLOCK) disable iff (RESET)
			state == S_IDLE && rx_cnt == 4'd0 |-> crc == mrsf_pkg::CRC_INIT;
	endproperty
	a_crc_preset: assert property (p_crc_preset) else $error("check not preset");

	property p_bad_count;
		@(posedge CLOCK) disable iff (RESET)
			state == S_SEND && is_read && !cnt_ok |-> exc == mrsf_pkg::EXC_DATA;
	endproperty
	a_bad_count: assert property (p_bad_count) else $error("bad count not refused");

	property p_bad_cmd;
		@(posedge CLOCK) disable iff (RESET) state == S_SEND && !cmd_ok |-> exc == mrsf_pkg::EXC_CMD;
	endproperty
	a_bad_cmd: assert property (p_bad_cmd) else $error("bad command not refused");

	property p_crc_low_first;
		@(posedge CLOCK) disable iff (RESET)
			state == S_SEND && tx_fire && tx_idx == body_len |=> TX_DATA == $past(crc[7:0]);
	endproperty
	a_crc_low_first: assert property (p_crc_low_first) else $error("check low byte wrong");

	property p_par_hold;
		@(posedge CLOCK) disable iff (RESET) PAR_REQ && !PAR_ACK |=> PAR_REQ && $stable(PAR);
	endproperty
	a_par_hold: assert property (p_par_hold) else $error("store request changed");

	property p_drop_foreign;
		@(posedge CLOCK) disable iff (RESET)
			state == S_IDLE && !RX_VALID && gap_cnt == GAP_END && rx_cnt != 4'd0 && !own && !bcast
			|=> state == S_IDLE ##1 !TX_EN;
	endproperty
	a_drop_foreign: assert property (p_drop_foreign) else $error("foreign frame acted on");

	property p_reply_ends;
		@(posedge CLOCK) disable iff (RESET)
			s_accept ##0 (state == S_SEND && tx_idx == body_len + 5'd2)
			|=> !TX_VALID && state == S_DRAIN;
	endproperty
	a_reply_ends: assert property (p_reply_ends) else $error("reply not closed");
endmodule : mrsf_framer

`default_nettype wire

/* logic/mrsf_pkg.sv */
// Constants and carrier types for the station frame engine.
// Assumes one 200 MHz clock and a byte-wide serial port beside the engine.
`default_nettype none

package mrsf_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam longint CLK_HZ = 200_000_000;
	localparam longint BAUD = 9600;
	localparam longint CHAR_BITS = 11;
	localparam longint GAP_TENTHS = 35;
	// Least gap, rounded up to whole cycles
	localparam longint GAP_CYCLES_L = (CLK_HZ * CHAR_BITS * GAP_TENTHS + BAUD * 10 - 1)
		/ (BAUD * 10);
	localparam int GAP_CYCLES = int'(GAP_CYCLES_L);

	// ----------------------------------------------------------------
	// Frame layout
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_BCAST = 8'h00;
	localparam logic [7:0] ADDR_MAX = 8'hF7;
	localparam logic [7:0] CMD_READ = 8'h03;
	localparam logic [7:0] CMD_WRITE = 8'h06;
	localparam logic [7:0] CMD_EXC_BIT = 8'h80;
	localparam logic [3:0] REQ_LEN = 4'h8;
	localparam logic [3:0] CRC_POS = 4'h6;
	localparam logic [15:0] MAX_WORDS = 16'h000C;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;

	// ----------------------------------------------------------------
	// Error codes
	// ----------------------------------------------------------------
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_CMD = 8'h01;
	localparam logic [7:0] EXC_ADDR = 8'h02;
	localparam logic [7:0] EXC_DATA = 8'h03;
	localparam logic [7:0] EXC_PROC = 8'h04;

	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mrsf_par_t;
endpackage : mrsf_pkg

`default_nettype wire

/* sim/mrsf_far.sv */
// Far-side model: byte serial port toward the master and a parameter store.
// Assumes the framer's byte and store handshakes on the same clock.
`default_nettype none

module mrsf_far (
	input wire logic clk,
	input wire logic rst,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_en,
	input wire logic par_req,
	input wire mrsf_pkg::mrsf_par_t par,
	input wire logic [3:0] stall,
	input wire logic [15:0] exc_addr,
	input wire logic [7:0] exc_code,
	output logic tx_ready,
	output logic tx_busy,
	output logic par_ack,
	output logic [7:0] par_exc,
	output logic [15:0] par_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] got[$];
	logic [15:0] wr_addr = 16'h0000;
	logic [15:0] wr_data = 16'h0000;
	int n_wr = 0;
	int n_bad = 0;
	int en_seen = 0;
	int wcnt = 0;
	int bcnt = 0;
	int scnt = 0;

	// Busy lasts a few cycles per byte; stall delays each ready
	always @(posedge clk) begin
		tx_ready <= 1'b0;
		if (tx_en)
			en_seen <= en_seen + 1;
		if (tx_valid && !tx_en)
			n_bad <= n_bad + 1;
		if (rst) begin
			tx_busy <= 1'b0;
			bcnt <= 0;
			wcnt <= 0;
		end else if (tx_valid && tx_ready) begin
			got.push_back(tx_data);
			tx_busy <= 1'b1;
			bcnt <= 6;
			wcnt <= 0;
		end else if (bcnt != 0) begin
			bcnt <= bcnt - 1;
		end else begin
			tx_busy <= 1'b0;
			if (tx_valid && !tx_busy)
				wcnt <= wcnt + 1;
			if (tx_valid && !tx_busy && wcnt >= int'(stall))
				tx_ready <= 1'b1;
		end
	end

	// Answer lines toggle outside an ack so stale values are never trusted
	always @(posedge clk) begin
		par_ack <= 1'b0;
		par_exc <= ~par_exc;
		par_rdata <= ~par_rdata;
		if (rst) begin
			scnt <= 0;
			par_exc <= 8'h00;
			par_rdata <= 16'h0000;
		end else if (par_req && !par_ack) begin
			scnt <= scnt + 1;
			if (scnt == 2) begin
				scnt <= 0;
				par_ack <= 1'b1;
				par_exc <= (par.addr == exc_addr) ? exc_code : 8'h00;
				par_rdata <= par.addr ^ 16'h5A5A;
				if (par.we && par.addr != exc_addr) begin
					n_wr <= n_wr + 1;
					wr_addr <= par.addr;
					wr_data <= par.wdata;
				end
			end
		end
	end
endmodule : mrsf_far

`default_nettype wire

/* sim/tb_modbus_rtu_slave_framer.sv */
// Self-checking bench for the station frame engine.
// Assumes the far-side model and the framer package are compiled first.
`default_nettype none

module tb_modbus_rtu_slave_framer;
	timeunit 1ns;
	timeprecision 100ps;
	typedef logic [7:0] mrsf_bq_t[$];
	localparam int GAP = 30;
	logic clk = 1'b0;
	logic rst, rx_valid, tx_valid, tx_ready, tx_busy, tx_en, par_req, par_ack;
	logic [7:0] station_addr, rx_data, tx_data, par_exc, exc_code;
	logic [15:0] par_rdata, exc_addr;
	logic [3:0] stall;
	mrsf_pkg::mrsf_par_t par;
	int n_errors = 0;
	int compares = 0;
	// Driver-enable count at the start of the latest request frame
	int en_base = 0;

	always #2.5 clk = ~clk;

	mrsf_framer #(.GAP_CYCLES(GAP)) mrsf_framer_inst (.CLOCK(clk), .RESET(rst),
		.STATION_ADDR(station_addr), .RX_VALID(rx_valid), .RX_DATA(rx_data),
		.TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_READY(tx_ready), .TX_BUSY(tx_busy),
		.TX_EN(tx_en), .PAR_REQ(par_req), .PAR(par), .PAR_ACK(par_ack),
		.PAR_EXC(par_exc), .PAR_RDATA(par_rdata));
	mrsf_far mrsf_far_inst (.clk(clk), .rst(rst), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_en(tx_en), .par_req(par_req), .par(par), .stall(stall), .exc_addr(exc_addr),
		.exc_code(exc_code), .tx_ready(tx_ready), .tx_busy(tx_busy), .par_ack(par_ack),
		.par_exc(par_exc), .par_rdata(par_rdata));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	function automatic logic [15:0] crc16(input mrsf_bq_t b);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (b[i]) begin
			c ^= {8'h00, b[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
		end
		return c;
	endfunction : crc16

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic send(input mrsf_bq_t b, input logic good);
		logic [15:0] c;
		c = crc16(b);
		b.push_back(c[7:0]);
		b.push_back(good ? c[15:8] : ~c[15:8]);
		en_base = mrsf_far_inst.en_seen;
		foreach (b[i]) begin
			@(posedge clk);
			rx_valid <= 1'b1;
			rx_data <= b[i];
			@(posedge clk);
			rx_valid <= 1'b0;
		end
	endtask : send

	task automatic expect_reply(input mrsf_bq_t b);
		logic [15:0] c;
		int n;
		c = crc16(b);
		b.push_back(c[7:0]);
		b.push_back(c[15:8]);
		n = 0;
		while ((mrsf_far_inst.got.size() < b.size() || tx_en) && n < 3000) begin
			@(posedge clk);
			n++;
		end
		repeat (GAP + 10) @(posedge clk);
		check(16'(mrsf_far_inst.got.size()), 16'(b.size()), "reply length");
		foreach (b[i])
			if (i < mrsf_far_inst.got.size())
				check({8'h00, mrsf_far_inst.got[i]}, {8'h00, b[i]}, "byte");
		mrsf_far_inst.got.delete();
	endtask : expect_reply

	task automatic expect_silence();
		repeat (GAP + 200) @(posedge clk);
		check(16'(mrsf_far_inst.got.size()), 16'h0000, "unwanted reply");
		check(16'(mrsf_far_inst.en_seen - en_base), 16'h0000, "driver enabled");
		mrsf_far_inst.got.delete();
	endtask : expect_silence

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_read_multi();
		stall <= 4'h3;
		send('{8'h11, 8'h03, 8'h10, 8'h00, 8'h00, 8'h02}, 1'b1);
		expect_reply('{8'h11, 8'h03, 8'h04, 8'h4A, 8'h5A, 8'h4A, 8'h5B});
		stall <= 4'h0;
	endtask : t_read_multi

	task automatic t_read_limits();
		mrsf_bq_t e;
		logic [15:0] w;
		e = '{8'h11, 8'h03, 8'h18};
		for (int i = 0; i < 12; i++) begin
			w = (16'h1010 + 16'(i)) ^ 16'h5A5A;
			e.push_back(w[15:8]);
			e.push_back(w[7:0]);
		end
		send('{8'h11, 8'h03, 8'h10, 8'h10, 8'h00, 8'h0C}, 1'b1);
		expect_reply(e);
		send('{8'h11, 8'h03, 8'h10, 8'h10, 8'h00, 8'h0D}, 1'b1);
		expect_reply('{8'h11, 8'h83, 8'h03});
		send('{8'h11, 8'h03, 8'h10, 8'h10, 8'h00, 8'h00}, 1'b1);
		expect_reply('{8'h11, 8'h83, 8'h03});
	endtask : t_read_limits

	task automatic t_write_and_broadcast();
		send('{8'h11, 8'h06, 8'h20, 8'h00, 8'h00, 8'h07}, 1'b1);
		expect_reply('{8'h11, 8'h06, 8'h20, 8'h00, 8'h00, 8'h07});
		check(mrsf_far_inst.wr_addr, 16'h2000, "write address");
		send('{8'h00, 8'h06, 8'h20, 8'h01, 8'h12, 8'h34}, 1'b1);
		expect_silence();
		check(mrsf_far_inst.wr_data, 16'h1234, "broadcast write");
		check(16'(mrsf_far_inst.n_wr), 16'h0002, "store writes");
	endtask : t_write_and_broadcast

	task automatic t_dropped();
		send('{8'h00, 8'h03, 8'h10, 8'h00, 8'h00, 8'h01}, 1'b1);
		expect_silence();
		send('{8'h12, 8'h03, 8'h10, 8'h00, 8'h00, 8'h01}, 1'b1);
		expect_silence();
		send('{8'h11, 8'h03, 8'h10, 8'h00, 8'h00, 8'h01}, 1'b0);
		expect_silence();
		send('{8'h00, 8'h05, 8'h10, 8'h00, 8'h00, 8'h01}, 1'b1);
		expect_silence();
		send('{8'h11, 8'h03, 8'h10, 8'h00}, 1'b1);
		expect_silence();
	endtask : t_dropped

	task automatic t_errors();
		send('{8'h11, 8'h01, 8'h10, 8'h00, 8'h00, 8'h01}, 1'b1);
		expect_reply('{8'h11, 8'h81, 8'h01});
		exc_addr <= 16'h3000;
		exc_code <= 8'h04;
		send('{8'h11, 8'h03, 8'h30, 8'h00, 8'h00, 8'h01}, 1'b1);
		expect_reply('{8'h11, 8'h83, 8'h04});
		exc_code <= 8'h02;
		send('{8'h11, 8'h06, 8'h30, 8'h00, 8'h00, 8'h05}, 1'b1);
		expect_reply('{8'h11, 8'h86, 8'h02});
	endtask : t_errors

	task automatic t_top_address();
		station_addr <= 8'hF7;
		send('{8'hF7, 8'h03, 8'h10, 8'h00, 8'h00, 8'h01}, 1'b1);
		expect_reply('{8'hF7, 8'h03, 8'h02, 8'h4A, 8'h5A});
		station_addr <= 8'hF8;
		send('{8'hF8, 8'h03, 8'h10, 8'h00, 8'h00, 8'h01}, 1'b1);
		expect_silence();
	endtask : t_top_address

	task automatic conclude();
		$display("Counts: %0d compares, %0d errors", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude

	initial begin
		rst = 1'b1;
		station_addr = 8'h11;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		stall = 4'h0;
		exc_addr = 16'hFFFF;
		exc_code = 8'h00;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_read_multi();
		t_read_limits();
		t_write_and_broadcast();
		t_dropped();
		t_errors();
		t_top_address();
		check(16'(mrsf_far_inst.n_bad), 16'h0000, "drive without enable");
		conclude();
	end

	// Whole run needs a few thousand cycles
	initial begin
		repeat (30000) @(posedge clk);
		n_errors++;
		conclude();
	end
endmodule : tb_modbus_rtu_slave_framer

`default_nettype wire
